// [hw/vrld_pkg.sv]
// Purpose: shared constants and types for the reference and low-voltage detect block
// Assumes: AXI4-Lite slave, 32-bit data, one aligned word per register
// Notes: registers hold 8 bits in the low lanes, upper bits read zero
package vrld_pkg;
  localparam logic [7:0] VRLD_REFCTL_ADDR = 8'h00;
  localparam logic [7:0] VRLD_LVCTL_ADDR = 8'h04;
  localparam logic [7:0] VRLD_STAT_ADDR = 8'h08;
  localparam logic [7:0] VRLD_IEN_ADDR = 8'h0C;
  localparam logic [7:0] VRLD_ICLR_ADDR = 8'h10;
  localparam logic [7:0] VRLD_MISC_ADDR = 8'h14;
  localparam int VRLD_HREN_BIT = 7;
  localparam int VRLD_LREN_BIT = 6;
  localparam int VRLD_HROE_BIT = 5;
  localparam int VRLD_LROE_BIT = 4;
  localparam int VRLD_BANDGAP_STABLE_BIT = 5;
  localparam int VRLD_LVEN_BIT = 4;
  localparam int VRLD_TRIP_LSB = 0;
  localparam int VRLD_TRIP_W = 4;
  localparam logic [3:0] VRLD_TRIP_EXT = 4'hF;
  localparam logic [7:0] VRLD_REFCTL_MASK = 8'hF0;
  localparam logic [7:0] VRLD_LVCTL_WMASK = 8'h1F;
  localparam logic [7:0] VRLD_RESET_VAL = 8'h00;
  localparam int VRLD_EV_LV = 0;
  localparam int VRLD_EV_BG = 1;
  localparam int VRLD_NEV = 2;
  localparam int VRLD_CLK_MHZ = 50;
  localparam int VRLD_BG_START_US = 50;
  // start-up time in clock cycles, 50 us at 50 MHz gives 2500
  localparam int VRLD_BG_START_CYC = VRLD_BG_START_US * VRLD_CLK_MHZ;
  localparam logic [1:0] VRLD_RESP_OK = 2'h0;
  localparam logic [1:0] VRLD_RESP_DEC = 2'h3;
  typedef struct packed {
    logic high_ref_enable;
    logic low_ref_enable;
    logic high_ref_pin_out_enable;
    logic low_ref_pin_out_enable;
  } vrld_refctl_s;
  typedef struct packed {
    logic high_ref_on;
    logic low_ref_on;
    logic high_ref_pin;
    logic low_ref_pin;
    logic bandgap_on;
    logic detector_on;
    logic ext_trip_sel;
    logic [3:0] trip_level;
  } vrld_analog_s;
endpackage : vrld_pkg

// [hw/vrld_top.sv]
// Purpose: bandgap, reference and low-voltage detect control with AXI4-Lite registers
// Assumes: analog status inputs synchronous to aclk
// Notes: one interrupt line covers low-voltage and bandgap-ready events
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
module vrld_top import vrld_pkg::*; #(
  parameter int BG_START_CYC = VRLD_BG_START_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system inputs
  input wire logic brownout_enable,
  input wire logic lowvolt_trip,
  input wire logic sleep_mode,
  // analog controls, wake request and interrupt
  output vrld_analog_s analog_ctl,
  output logic wake_req,
  output logic irq
);
  vrld_refctl_s ref_ff;
  logic lv_en_ff;
  logic [3:0] trip_ff;
  logic [VRLD_NEV-1:0] stat_ff;
  logic [VRLD_NEV-1:0] ien_ff;
  logic bg_stable_ff;
  logic [$clog2(BG_START_CYC+1)-1:0] bg_cnt_ff;
  logic bg_req;
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb0_ff;
  logic wr_do;
  logic [7:0] rd_val;
  logic rd_hit;
  logic wr_hit;
  logic lv_set;
  logic bg_set;
  logic [VRLD_NEV-1:0] clr_vec;
  logic [VRLD_NEV-1:0] nxt_stat;

  // bandgap request is any user
  assign bg_req = brownout_enable | lv_en_ff | ref_ff.high_ref_enable
    | ref_ff.low_ref_enable;

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
  assign wr_do = aw_got_ff && w_got_ff && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (wr_do) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_ff <= 1'b0;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_ff <= 1'b1;
      wdata_ff <= s_axi_wdata[7:0];
      wstrb0_ff <= s_axi_wstrb[0];
    end else if (wr_do) begin
      w_got_ff <= 1'b0;
    end
  end

  always_comb begin
    case (awaddr_ff)
      VRLD_REFCTL_ADDR, VRLD_LVCTL_ADDR, VRLD_STAT_ADDR,
      VRLD_IEN_ADDR, VRLD_ICLR_ADDR, VRLD_MISC_ADDR: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= VRLD_RESP_OK;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? VRLD_RESP_OK : VRLD_RESP_DEC;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // reference control register, low nibble not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_ff <= vrld_refctl_s'(VRLD_RESET_VAL[7:4]);
    end else if (wr_do && wstrb0_ff && awaddr_ff == VRLD_REFCTL_ADDR) begin
      ref_ff <= vrld_refctl_s'(wdata_ff[7:4]);
    end
  end

  // detector control; stable bit is not writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lv_en_ff <= 1'b0;
      trip_ff <= VRLD_RESET_VAL[3:0];
    end else if (wr_do && wstrb0_ff && awaddr_ff == VRLD_LVCTL_ADDR) begin
      lv_en_ff <= wdata_ff[VRLD_LVEN_BIT];
      trip_ff <= wdata_ff[VRLD_TRIP_LSB +: VRLD_TRIP_W];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ien_ff <= '0;
    end else if (wr_do && wstrb0_ff && awaddr_ff == VRLD_IEN_ADDR) begin
      ien_ff <= wdata_ff[VRLD_NEV-1:0];
    end
  end

  // bandgap start-up timer; stable drops at once when unpowered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bg_cnt_ff <= '0;
      bg_stable_ff <= 1'b0;
    end else if (!bg_req) begin
      bg_cnt_ff <= '0;
      bg_stable_ff <= 1'b0;
    end else if (!bg_stable_ff) begin
      if (bg_cnt_ff == ($bits(bg_cnt_ff))'(BG_START_CYC - 1)) begin
        bg_stable_ff <= 1'b1;
      end else begin
        bg_cnt_ff <= bg_cnt_ff + 1'b1;
      end
    end
  end

  // events; set wins over clear
  assign lv_set = lv_en_ff && bg_stable_ff && lowvolt_trip;
  assign bg_set = bg_req && !bg_stable_ff && bg_cnt_ff == ($bits(bg_cnt_ff))'(BG_START_CYC - 1);
  assign clr_vec = (wr_do && wstrb0_ff && awaddr_ff == VRLD_ICLR_ADDR)
    ? wdata_ff[VRLD_NEV-1:0] : '0;

  always_comb begin
    nxt_stat = stat_ff & ~clr_vec;
    nxt_stat[VRLD_EV_LV] = lv_set || (stat_ff[VRLD_EV_LV] && !clr_vec[VRLD_EV_LV]);
    nxt_stat[VRLD_EV_BG] = bg_set || nxt_stat[VRLD_EV_BG];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // pending irq also requests wake while asleep
  assign irq = |(stat_ff & ien_ff);
  assign wake_req = irq && sleep_mode;

  // analog controls are combinational from registers and the brownout_enable input
  always_comb begin
    analog_ctl.high_ref_on = ref_ff.high_ref_enable;
    analog_ctl.low_ref_on = ref_ff.low_ref_enable;
    analog_ctl.high_ref_pin = ref_ff.high_ref_enable
      && ref_ff.high_ref_pin_out_enable;
    analog_ctl.low_ref_pin = ref_ff.low_ref_enable
      && ref_ff.low_ref_pin_out_enable;
    analog_ctl.bandgap_on = bg_req;
    analog_ctl.detector_on = lv_en_ff;
    analog_ctl.ext_trip_sel = trip_ff == VRLD_TRIP_EXT;
    analog_ctl.trip_level = trip_ff;
  end

  // read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      VRLD_REFCTL_ADDR: rd_val = {ref_ff, 4'h0} & VRLD_REFCTL_MASK;
      VRLD_LVCTL_ADDR: rd_val = {2'b00, bg_stable_ff, lv_en_ff, trip_ff};
      VRLD_STAT_ADDR: rd_val[VRLD_NEV-1:0] = stat_ff;
      VRLD_IEN_ADDR: rd_val[VRLD_NEV-1:0] = ien_ff;
      VRLD_ICLR_ADDR: rd_val = 8'h00;
      VRLD_MISC_ADDR: rd_val[1:0] = {lowvolt_trip, bg_req};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= VRLD_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_val};
      s_axi_rresp <= rd_hit ? VRLD_RESP_OK : VRLD_RESP_DEC;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks: bus handshake first, then the analog rules
  aw_refuse_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken under response");
  ar_refuse_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken under response");
  bvalid_after_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_do |=> s_axi_bvalid)
    else $error("no write response");
  rvalid_after_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("no read response");
  bvalid_cause_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_bvalid) |-> $past(wr_do))
    else $error("write response without write");
  rvalid_cause_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready))
    else $error("read response without read");
  bvalid_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rvalid_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped early");
  rdata_upper_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  bresp_ok_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_do && wr_hit) |=> s_axi_bresp == VRLD_RESP_OK)
    else $error("mapped write not okay");
  bresp_dec_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_do && !wr_hit) |=> s_axi_bresp == VRLD_RESP_DEC)
    else $error("unmapped write not decode error");
  rd_unmapped_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && !rd_hit)
    |=> s_axi_rresp == VRLD_RESP_DEC && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not decode error");
  lvctl_top_zero_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == VRLD_LVCTL_ADDR)
    |=> s_axi_rdata[7:6] == 2'b00)
    else $error("detector control top bits not zero");
  ref_write_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_do && wstrb0_ff && awaddr_ff == VRLD_REFCTL_ADDR)
    |=> {ref_ff, 4'h0} == ($past(wdata_ff) & VRLD_REFCTL_MASK))
    else $error("reference control write lost");
  ref_keep_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !(wr_do && wstrb0_ff && awaddr_ff == VRLD_REFCTL_ADDR) |=> $stable(ref_ff))
    else $error("reference control changed unasked");
  lv_write_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_do && wstrb0_ff && awaddr_ff == VRLD_LVCTL_ADDR)
    |=> {3'b000, lv_en_ff, trip_ff} == ($past(wdata_ff) & VRLD_LVCTL_WMASK))
    else $error("detector control write lost");
  lv_keep_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !(wr_do && wstrb0_ff && awaddr_ff == VRLD_LVCTL_ADDR)
    |=> $stable(lv_en_ff) && $stable(trip_ff))
    else $error("detector control changed unasked");
  ien_write_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_do && wstrb0_ff && awaddr_ff == VRLD_IEN_ADDR)
    |=> ien_ff == VRLD_NEV'($past(wdata_ff)))
    else $error("interrupt enable write lost");
  bg_count_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    int'(bg_cnt_ff) < BG_START_CYC)
    else $error("start-up counter overran");
  bg_rise_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    bg_set |=> bg_stable_ff)
    else $error("stable not raised at end of start-up");
  bg_keep_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (bg_stable_ff && bg_req) |=> bg_stable_ff)
    else $error("stable dropped while powered");
  bg_event_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    bg_set |=> stat_ff[VRLD_EV_BG])
    else $error("bandgap ready event lost");
  lv_sticky_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (stat_ff[VRLD_EV_LV] && !clr_vec[VRLD_EV_LV]) |=> stat_ff[VRLD_EV_LV])
    else $error("flag dropped without clear");
  lv_clear_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (stat_ff[VRLD_EV_LV] && clr_vec[VRLD_EV_LV] && !lv_set) |=> !stat_ff[VRLD_EV_LV])
    else $error("flag not cleared once untripped");
  irq_on_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (stat_ff[VRLD_EV_LV] && ien_ff[VRLD_EV_LV]) |-> irq)
    else $error("enabled flag without interrupt");
  wake_cause_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wake_req |-> sleep_mode && irq)
    else $error("wake without pending interrupt");
  bg_req_or_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    analog_ctl.bandgap_on == (brownout_enable | lv_en_ff
    | ref_ff.high_ref_enable | ref_ff.low_ref_enable))
    else $error("bandgap request mismatch");
  hpin_gate_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    analog_ctl.high_ref_pin |-> analog_ctl.high_ref_on)
    else $error("high pin without reference");
  lpin_gate_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    analog_ctl.low_ref_pin |-> analog_ctl.low_ref_on)
    else $error("low pin without reference");
  ref_low_zero_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == VRLD_REFCTL_ADDR)
    |=> s_axi_rdata[3:0] == 4'h0)
    else $error("reserved bits not zero");
  bg_start_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(bg_req) |-> !bg_stable_ff [*8])
    else $error("bandgap stable too early");
  bg_drop_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !bg_req |=> !bg_stable_ff)
    else $error("stable while unpowered");
  lv_block_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(stat_ff[VRLD_EV_LV]) |-> $past(bg_stable_ff) && $past(lv_en_ff))
    else $error("flag set without stable bandgap");
  lv_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (lv_en_ff && bg_stable_ff && lowvolt_trip) |=> stat_ff[VRLD_EV_LV])
    else $error("flag cleared while tripped");
  ext_sel_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    analog_ctl.ext_trip_sel == (analog_ctl.trip_level == VRLD_TRIP_EXT))
    else $error("external select mismatch");
  wake_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (sleep_mode && stat_ff[VRLD_EV_LV] && ien_ff[VRLD_EV_LV]) |-> wake_req && irq)
    else $error("no wake on pending interrupt");
  ctl_en_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    analog_ctl.detector_on == lv_en_ff)
    else $error("detector enable mismatch");
endmodule : vrld_top

// [bench/tb.sv]
// Purpose: self-checking bench for vrld_top through its AXI4-Lite registers
// Assumes: bandgap start-up shortened to BGC cycles, wstrb tied to all lanes
// Notes: assertions live in the design files, so no checker here
`timescale 1ns/10ps
module tb import vrld_pkg::*; ;
  // short count keeps the run brief, expectations follow it
  localparam int BGC = 10;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic bor_en = 1'b0;
  logic trip = 1'b0;
  logic sleep = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, wake, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  vrld_analog_s ana_ctl;
  int errors = 0;
  int cmp_count = 0;

  always #10 aclk = ~aclk;

  vrld_top #(.BG_START_CYC(BGC)) dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .brownout_enable(bor_en), .lowvolt_trip(trip), .sleep_mode(sleep),
    .analog_ctl(ana_ctl), .wake_req(wake), .irq(irq)
  );

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // ready is combinational, so it is judged at the falling edge before the take
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw_h, w_h, b_h;
    logic [1:0] rs;
    n = 0;
    b_h = 1'b0;
    rs = 2'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_h && n < 100) begin
      @(negedge aclk);
      aw_h = awvalid && awready;
      w_h = wvalid && wready;
      b_h = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (aw_h) awvalid <= 1'b0;
      if (w_h) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, rs}, {30'h0, er});
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    int n;
    logic a_h, r_h;
    logic [31:0] d;
    logic [1:0] rs;
    n = 0;
    r_h = 1'b0;
    d = 32'h0;
    rs = 2'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_h && n < 100) begin
      @(negedge aclk);
      a_h = arvalid && arready;
      r_h = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge aclk);
      if (a_h) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    chk("rdata", d, ex);
    chk("rresp", {30'h0, rs}, {30'h0, er});
  endtask : rdc

  task automatic ana(input logic [3:0] refs, input logic bg, input logic det, input logic ext,
                     input logic [3:0] lvl);
    @(negedge aclk);
    chk("analog", {21'h0, ana_ctl}, {21'h0, refs, bg, det, ext, lvl});
  endtask : ana

  task automatic irqc(input logic ei, input logic ew);
    @(negedge aclk);
    chk("irq", {31'h0, irq}, {31'h0, ei});
    chk("wake", {31'h0, wake}, {31'h0, ew});
  endtask : irqc

  task automatic t_reset();
    rdc(VRLD_REFCTL_ADDR, 32'h0, VRLD_RESP_OK);
    rdc(VRLD_LVCTL_ADDR, 32'h0, VRLD_RESP_OK);
    rdc(VRLD_STAT_ADDR, 32'h0, VRLD_RESP_OK);
    rdc(VRLD_IEN_ADDR, 32'h0, VRLD_RESP_OK);
    ana(4'h0, 1'b0, 1'b0, 1'b0, 4'h0);
    irqc(1'b0, 1'b0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_refs();
    wr(VRLD_REFCTL_ADDR, 32'hFF, VRLD_RESP_OK);
    rdc(VRLD_REFCTL_ADDR, 32'hF0, VRLD_RESP_OK);
    ana(4'hF, 1'b1, 1'b0, 1'b0, 4'h0);
    rdc(VRLD_MISC_ADDR, 32'h1, VRLD_RESP_OK);
    wr(VRLD_REFCTL_ADDR, 32'h30, VRLD_RESP_OK);
    ana(4'h0, 1'b0, 1'b0, 1'b0, 4'h0);
    wr(VRLD_REFCTL_ADDR, 32'hA0, VRLD_RESP_OK);
    ana(4'hA, 1'b1, 1'b0, 1'b0, 4'h0);
    wr(VRLD_REFCTL_ADDR, 32'h50, VRLD_RESP_OK);
    ana(4'h5, 1'b1, 1'b0, 1'b0, 4'h0);
    wr(VRLD_REFCTL_ADDR, 32'h0, VRLD_RESP_OK);
    @(posedge aclk);
    bor_en <= 1'b1;
    ana(4'h0, 1'b1, 1'b0, 1'b0, 4'h0);
    @(posedge aclk);
    bor_en <= 1'b0;
    ana(4'h0, 1'b0, 1'b0, 1'b0, 4'h0);
    $display("test refs done");
  endtask : t_refs

  task automatic t_bandgap();
    wr(VRLD_ICLR_ADDR, 32'h3, VRLD_RESP_OK);
    wr(VRLD_REFCTL_ADDR, 32'h80, VRLD_RESP_OK);
    rdc(VRLD_LVCTL_ADDR, 32'h0, VRLD_RESP_OK);
    repeat (BGC) @(posedge aclk);
    rdc(VRLD_LVCTL_ADDR, 32'h20, VRLD_RESP_OK);
    rdc(VRLD_STAT_ADDR, 32'h2, VRLD_RESP_OK);
    wr(VRLD_REFCTL_ADDR, 32'h0, VRLD_RESP_OK);
    rdc(VRLD_LVCTL_ADDR, 32'h0, VRLD_RESP_OK);
    wr(VRLD_LVCTL_ADDR, 32'hFF, VRLD_RESP_OK);
    rdc(VRLD_LVCTL_ADDR, 32'h1F, VRLD_RESP_OK);
    wr(VRLD_LVCTL_ADDR, 32'h0, VRLD_RESP_OK);
    $display("test bandgap done");
  endtask : t_bandgap

  // trip raised before the detector starts, so the flag must wait for stable
  task automatic t_lowvolt();
    wr(VRLD_ICLR_ADDR, 32'h3, VRLD_RESP_OK);
    @(posedge aclk);
    trip <= 1'b1;
    wr(VRLD_LVCTL_ADDR, 32'h03, VRLD_RESP_OK);
    rdc(VRLD_STAT_ADDR, 32'h0, VRLD_RESP_OK);
    wr(VRLD_LVCTL_ADDR, 32'h13, VRLD_RESP_OK);
    rdc(VRLD_STAT_ADDR, 32'h0, VRLD_RESP_OK);
    ana(4'h0, 1'b1, 1'b1, 1'b0, 4'h3);
    repeat (BGC) @(posedge aclk);
    rdc(VRLD_STAT_ADDR, 32'h3, VRLD_RESP_OK);
    irqc(1'b0, 1'b0);
    wr(VRLD_IEN_ADDR, 32'h1, VRLD_RESP_OK);
    irqc(1'b1, 1'b0);
    @(posedge aclk);
    sleep <= 1'b1;
    irqc(1'b1, 1'b1);
    wr(VRLD_ICLR_ADDR, 32'h1, VRLD_RESP_OK);
    rdc(VRLD_STAT_ADDR, 32'h3, VRLD_RESP_OK);
    wr(VRLD_IEN_ADDR, 32'h0, VRLD_RESP_OK);
    irqc(1'b0, 1'b0);
    @(posedge aclk);
    trip <= 1'b0;
    sleep <= 1'b0;
    wr(VRLD_ICLR_ADDR, 32'h3, VRLD_RESP_OK);
    rdc(VRLD_STAT_ADDR, 32'h0, VRLD_RESP_OK);
    for (int i = 0; i < 16; i++) begin
      wr(VRLD_LVCTL_ADDR, 32'(16 + i), VRLD_RESP_OK);
      ana(4'h0, 1'b1, 1'b1, (4'(i) == VRLD_TRIP_EXT), 4'(i));
    end
    wr(VRLD_LVCTL_ADDR, 32'h0, VRLD_RESP_OK);
    $display("test lowvolt done");
  endtask : t_lowvolt

  task automatic t_bus();
    wr(8'h20, 32'h1, VRLD_RESP_DEC);
    rdc(8'h20, 32'h0, VRLD_RESP_DEC);
    rdc(VRLD_ICLR_ADDR, 32'h0, VRLD_RESP_OK);
    $display("test bus done");
  endtask : t_bus

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // whole run needs a few hundred cycles, limit is 5000
  initial begin
    #100000;
    errors++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_refs();
    t_bandgap();
    t_lowvolt();
    t_bus();
    end_of_test();
  end
endmodule : tb
